// *** include/root_port_map.vh ***
// register map, field positions and timing for the root port block
// assumes a 200 MHz core clock and a byte-addressed wishbone slave
`ifndef ROOT_PORT_MAP_VH
`define ROOT_PORT_MAP_VH

// byte offsets on the register bus
`define RP_CMD_OFS 8'h00
`define RP_STS_OFS 8'h04
`define RP_PSC0_OFS 8'h10
`define RP_PSC_STRIDE 8'h04

// host command register
`define RP_CMD_GSUSP 3
`define RP_CMD_FGRES 4

// host status register
`define RP_STS_RESDET 2

// port status/control register
`define RP_PSC_PRES 0
`define RP_PSC_CCHG 1
`define RP_PSC_EN 2
`define RP_PSC_ENCHG 3
`define RP_PSC_RESUME 6
`define RP_PSC_ONE 7
`define RP_PSC_PRST 9
`define RP_PSC_SUSP 12
`define RP_PSC_W 16

// timing
`define RP_CLK_PS 5000
`define RP_EOP_NS 1330

`endif

// *** hdl/pin_sync.v ***
// two-stage synchroniser for a group of asynchronous pin levels
// assumes nothing but a free-running clock; only stage two is read
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter W = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule // pin_sync

`default_nettype wire

// *** hdl/wb_reg_slave.v ***
// classic wishbone slave front end: one wait state, registered ack and data
// assumes the master holds the request until it samples ack
`timescale 1ns/1ps
`default_nettype none

module wb_reg_slave #(
  parameter DW = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [DW-1:0] rdata_i,
  output wire wr_o,
  output wire [DW-1:0] dat_o,
  output wire ack_o
);

  reg ack_ff;
  reg [DW-1:0] dat_ff;

  // ack is high one cycle and drops even if the master lingers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= {DW{1'b0}};
    end else begin
      ack_ff <= cyc_i & stb_i & ~ack_ff;
      if (cyc_i & stb_i & ~we_i & ~ack_ff)
        dat_ff <= rdata_i;
    end
  end

  // the write lands on the edge where the master sees ack
  assign wr_o = cyc_i & stb_i & we_i & ack_ff;
  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

endmodule // wb_reg_slave

`default_nettype wire

// *** hdl/root_port.v ***
// root hub port logic: connect detect, change flags, selective and global resume
// assumes present and k-state pins are asynchronous levels, one bus master
//
// Operation
// - any presence change sets connect-change flag
// - write one clears connect change flag
// - present bit follows live attach state
// - k-state seen only on enabled port, when selectively or globally suspended
// - global suspend resume sets host resume-detected
// - force global resume drives k everywhere enabled
// - port bit six forces resume when suspended
// - clearing suspend and resume bits ends signalling
// - local suspended k reflected, sets port flag
// - disconnect clears present, enable; sets changes
// - connect sets present and connect change
// - global: enabled k wakes host, adjacent ports
// - global: suspended k sets both resume flags
// - global: disconnect wakes host and adjacent ports
// - global: connect wakes host and adjacent ports
`timescale 1ns/1ps
`default_nettype none
`include "root_port_map.vh"

module root_port #(
  parameter NP = 2,
  parameter EOP_CYC = (`RP_EOP_NS * 1000 + `RP_CLK_PS - 1) / `RP_CLK_PS
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire [NP-1:0] present_i,
  input wire [NP-1:0] kstate_i,
  output wire [NP-1:0] kdrive_o,
  output wire [NP-1:0] se0_o
);

  localparam [7:0] CMD_A = `RP_CMD_OFS;
  localparam [7:0] STS_A = `RP_STS_OFS;
  localparam [7:0] PSC_A = `RP_PSC0_OFS;
  localparam [7:0] PSC_S = `RP_PSC_STRIDE;
  // the count is cut to nine bits on purpose; longer eops need a wider counter
  localparam [31:0] EOP_W = EOP_CYC;
  localparam [8:0] EOP_N = EOP_W[8:0];
  localparam [8:0] ZERO9 = 9'h000;

  wire wr;
  wire we_lo;
  wire we_hi;
  wire [NP-1:0] pres_s;
  wire [NP-1:0] k_s;
  wire [NP-1:0] gevt;
  wire [NP-1:0] lsel;
  wire [16*NP-1:0] psc_rd;
  reg [31:0] rdata;

  reg gsusp_ff;
  reg fgres_ff;
  reg resdet_ff;

  pin_sync #(
    .W(2 * NP)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({kstate_i, present_i}),
    .q_o({k_s, pres_s})
  );

  wb_reg_slave #(
    .DW(32)
  ) u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .rdata_i(rdata),
    .wr_o(wr),
    .dat_o(dat_o),
    .ack_o(ack_o)
  );

  // ack comes one cycle after the request; the write lands with ack
  assign we_lo = wr & sel_i[0];
  assign we_hi = wr & sel_i[1];

  // host command: global suspend and force global resume
  // no interlock against clearing port bits first; software keeps the order
  always @(posedge clk_i) begin
    if (rst_i) begin
      gsusp_ff <= 1'b0;
      fgres_ff <= 1'b0;
    end else if (we_lo && adr_i[7:2] == CMD_A[7:2]) begin
      gsusp_ff <= dat_i[`RP_CMD_GSUSP];
      fgres_ff <= dat_i[`RP_CMD_FGRES];
    end
  end

  // host resume-detected; a wake event wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      resdet_ff <= 1'b0;
    end else if (|gevt) begin
      resdet_ff <= 1'b1;
    end else if (we_lo && adr_i[7:2] == STS_A[7:2] && dat_i[`RP_STS_RESDET]) begin
      resdet_ff <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NP; i = i + 1) begin : g_port
      localparam [31:0] MY_W = PSC_A + PSC_S * i;
      localparam [7:0] MY_A = MY_W[7:0];
      wire hit;
      wire wlo;
      wire whi;
      wire conn;
      wire disc;
      wire kev;
      wire others;
      wire adj;
      reg pres_d_ff;
      reg k_d_ff;
      reg cchg_ff;
      reg en_ff;
      reg enchg_ff;
      reg res_ff;
      reg resend_ff;
      reg susp_ff;
      reg prst_ff;
      reg gres_ff;
      reg kdrv_ff;
      reg se0_ff;
      reg [8:0] eop_ff;
      reg nxt_kdrv;
      reg [8:0] nxt_eop;

      assign hit = adr_i[7:2] == MY_A[7:2];
      assign lsel[i] = hit;
      assign wlo = we_lo & hit;
      assign whi = we_hi & hit;

      // edges of the synchronised levels; only stage two feeds these
      assign conn = pres_s[i] & ~pres_d_ff;
      assign disc = ~pres_s[i] & pres_d_ff;
      assign kev = k_s[i] & ~k_d_ff & en_ff;

      // wake event under global suspend on this port
      assign gevt[i] = gsusp_ff & (kev | conn | disc);

      // wake events raised by any port but this one
      assign others = |(gevt & ~({{(NP-1){1'b0}}, 1'b1} << i));

      // only enabled, not suspended ports carry another port's resume
      assign adj = en_ff & ~susp_ff;

      always @(posedge clk_i) begin
        if (rst_i) begin
          pres_d_ff <= 1'b0;
          k_d_ff <= 1'b0;
        end else begin
          pres_d_ff <= pres_s[i];
          k_d_ff <= k_s[i];
        end
      end

      // connect change: repeated changes leave it set, no history kept
      always @(posedge clk_i) begin
        if (rst_i) begin
          cchg_ff <= 1'b0;
        end else if (conn | disc) begin
          cchg_ff <= 1'b1;
        end else if (wlo && dat_i[`RP_PSC_CCHG]) begin
          cchg_ff <= 1'b0;
        end
      end

      // enable; a disconnect or port reset takes priority over software
      always @(posedge clk_i) begin
        if (rst_i) begin
          en_ff <= 1'b0;
        end else if (disc | prst_ff) begin
          en_ff <= 1'b0;
        end else if (wlo) begin
          en_ff <= dat_i[`RP_PSC_EN];
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          enchg_ff <= 1'b0;
        end else if (disc) begin
          enchg_ff <= 1'b1;
        end else if (wlo && dat_i[`RP_PSC_ENCHG]) begin
          enchg_ff <= 1'b0;
        end
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          susp_ff <= 1'b0;
          prst_ff <= 1'b0;
        end else if (whi) begin
          susp_ff <= dat_i[`RP_PSC_SUSP];
          prst_ff <= dat_i[`RP_PSC_PRST];
        end
      end

      // port resume bit: set by software or by k on a suspended port;
      // a written zero only arms the end, the bit falls after the eop
      always @(posedge clk_i) begin
        if (rst_i) begin
          res_ff <= 1'b0;
          resend_ff <= 1'b0;
        end else if (kev && susp_ff) begin
          res_ff <= 1'b1;
          resend_ff <= 1'b0;
        end else if (wlo && dat_i[`RP_PSC_RESUME]) begin
          res_ff <= 1'b1;
          resend_ff <= 1'b0;
        end else if (wlo && res_ff) begin
          resend_ff <= 1'b1;
        end else if (resend_ff && !kdrv_ff && eop_ff == ZERO9) begin
          res_ff <= 1'b0;
          resend_ff <= 1'b0;
        end
      end

      // global resume on this port: reflected own k or adjacent wake
      always @(posedge clk_i) begin
        if (rst_i) begin
          gres_ff <= 1'b0;
        end else if (!gsusp_ff && !fgres_ff) begin
          gres_ff <= 1'b0;
        end else if (!en_ff) begin
          gres_ff <= 1'b0;
        end else if (gsusp_ff && adj && (kev | others)) begin
          gres_ff <= 1'b1;
        end
      end

      // k drive only on enabled ports; ending it starts the se0 eop
      always @* begin
        nxt_kdrv = en_ff & ((susp_ff & res_ff & ~resend_ff) | fgres_ff | gres_ff);
        nxt_eop = eop_ff;
        if (kdrv_ff && !nxt_kdrv)
          nxt_eop = EOP_N;
        else if (eop_ff != ZERO9)
          nxt_eop = eop_ff - 9'h001;
      end

      always @(posedge clk_i) begin
        if (rst_i) begin
          kdrv_ff <= 1'b0;
          se0_ff <= 1'b0;
          eop_ff <= ZERO9;
        end else begin
          kdrv_ff <= nxt_kdrv;
          se0_ff <= nxt_eop != ZERO9;
          eop_ff <= nxt_eop;
        end
      end

      assign kdrive_o[i] = kdrv_ff;
      assign se0_o[i] = se0_ff;

      // present reads the live level, not the latched event
      assign psc_rd[16*i +: 16] = {
        3'h0, susp_ff, 2'h0, prst_ff, 1'b0,
        1'b1, res_ff, 2'h0, enchg_ff, en_ff, cchg_ff, pres_s[i]
      };
    end
  endgenerate

  // read mux; unmapped addresses read zero
  // combinational so the slave registers it once, in the request cycle
  integer j;
  always @* begin
    rdata = 32'h00000000;
    if (adr_i[7:2] == CMD_A[7:2]) begin
      rdata[`RP_CMD_GSUSP] = gsusp_ff;
      rdata[`RP_CMD_FGRES] = fgres_ff;
    end
    if (adr_i[7:2] == STS_A[7:2])
      rdata[`RP_STS_RESDET] = resdet_ff;
    for (j = 0; j < NP; j = j + 1) begin
      if (lsel[j])
        rdata[15:0] = psc_rd[16*j +: 16];
    end
  end

endmodule // root_port

`default_nettype wire

// *** tb/root_port_properties.sv ***
// assertions on the root port bus and downstream pins
// assumes a classic wishbone master that holds each request until ack
`timescale 1ns/1ps
`default_nettype none
module root_port_properties #(
  parameter NP = 2,
  parameter EOP_CYC = 266
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [NP-1:0] present_i,
  input wire logic [NP-1:0] kstate_i,
  input wire logic [NP-1:0] kdrive_o,
  input wire logic [NP-1:0] se0_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] eop_run_ff;
  // length of the current end-of-resume run on port 0
  always @(posedge clk_i) begin
    if (rst_i || !se0_o[0])
      eop_run_ff <= 16'h0;
    else
      eop_run_ff <= eop_run_ff + 16'h1;
  end
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  AST_UPPER_ZERO: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (ack_o && !we_i && adr_i[7:2] == 6'h08 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_PRES_LIVE: assert property (ack_o && !we_i && adr_i == 8'h10 &&
    $past(present_i[0], 8) == present_i[0] |-> dat_o[0] == present_i[0])
    else $error("present bit stale");
  AST_K_SE0_APART: assert property ((kdrive_o & se0_o) == '0)
    else $error("k and se0 together");
  AST_EOP_AFTER_K: assert property ($fell(kdrive_o[0]) && !$past(rst_i) |-> ##[0:2] se0_o[0])
    else $error("no se0 after resume");
  AST_EOP_LEN: assert property ($fell(se0_o[0]) |-> eop_run_ff == EOP_CYC)
    else $error("se0 length wrong");
  AST_DETACHED_QUIET: assert property (!present_i[1] && !$past(present_i[1], 8)
    |-> !kdrive_o[1])
    else $error("k on detached port");
  AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !ack_o && kdrive_o == '0)
    else $error("outputs active in reset");
  cover property ($rose(kdrive_o[0]));
  cover property ($fell(se0_o[0]));
  cover property (ack_o && !we_i && adr_i == 8'h04 && dat_o[2]);
endmodule // root_port_properties
bind root_port root_port_properties #(.NP(NP), .EOP_CYC(EOP_CYC)) props (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .present_i(present_i),
  .kstate_i(kstate_i), .kdrive_o(kdrive_o), .se0_o(se0_o));
`default_nettype wire

// *** tb/usb_dev_model.sv ***
// two downstream devices: attach level and resume k on request
// assumes the bench asks for attach and wake right after clock edges
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model (
  input wire logic clk_i,
  input wire logic [1:0] attach_i,
  input wire logic [1:0] wake_i,
  output logic [1:0] present_o = 2'b00,
  output logic [1:0] kstate_o = 2'b00
);
  always @(posedge clk_i) begin
    present_o <= attach_i;
    // a detached line has no device left to signal k
    kstate_o <= attach_i & wake_i;
  end
endmodule // usb_dev_model
`default_nettype wire

// *** tb/usb_root_port_resume_connect_test.sv ***
// self-checking bench for the root port with two modelled devices
// assumes one wishbone master and end-of-resume shortened to four cycles
`timescale 1ns/1ps
`default_nettype none
module usb_root_port_resume_connect_test;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic ack;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [1:0] attach = 2'b00;
  logic [1:0] wake = 2'b00;
  logic [1:0] pres, kst, kdrive, se0;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  row_t rows [6];
  root_port #(.NP(2), .EOP_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rdat),
    .ack_o(ack), .present_i(pres), .kstate_i(kst), .kdrive_o(kdrive), .se0_o(se0));
  usb_dev_model dev (.clk_i(clk_i), .attach_i(attach), .wake_i(wake), .present_o(pres),
    .kstate_o(kst));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic w(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // one classic cycle; the wait is bounded so a dead slave ends the run
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      print_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic pins(input logic [1:0] at, input logic [1:0] wk);
    attach <= at;
    wake <= wk;
    w(8);
    wake <= 2'b00;
    w(4);
  endtask
  initial begin
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'h80}, '{1'b0, 8'h14, 32'h0, 32'h80},
      '{1'b1, 8'h20, 32'hFFFF, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0}};
    w(16);
    rst_i <= 1'b0;
    w(1);
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rd(rows[i].a, rows[i].e);
    end
    pins(2'b01, 2'b00);
    rd(8'h10, 32'h83);
    rd(8'h14, 32'h80);
    pins(2'b00, 2'b00);
    pins(2'b01, 2'b00);
    rd(8'h10, 32'h8B);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h8B);
    wr(8'h10, 32'hA);
    rd(8'h10, 32'h81);
    pins(2'b11, 2'b00);
    pins(2'b11, 2'b10);
    rd(8'h14, 32'h83);
    rd(8'h04, 32'h0);
    wr(8'h10, 32'h1004);
    pins(2'b11, 2'b01);
    rd(8'h10, 32'h10C5);
    chk("kdrive", 32'h1, kdrive);
    wr(8'h10, 32'h4);
    for (n = 0; n < 20 && se0 !== 2'b01; n++)
      @(posedge clk_i);
    chk("se0", 32'h1, se0);
    w(12);
    rd(8'h10, 32'h85);
    wr(8'h14, 32'h6);
    wr(8'h00, 32'h8);
    pins(2'b11, 2'b01);
    rd(8'h04, 32'h4);
    chk("kdrive", 32'h3, kdrive);
    wr(8'h00, 32'h0);
    w(12);
    chk("kdrive", 32'h0, kdrive);
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h10);
    w(3);
    chk("kdrive", 32'h3, kdrive);
    wr(8'h00, 32'h0);
    w(12);
    wr(8'h10, 32'h1004);
    wr(8'h10, 32'h1044);
    w(3);
    chk("kdrive", 32'h1, kdrive);
    wr(8'h10, 32'h4);
    w(12);
    wr(8'h00, 32'h8);
    pins(2'b01, 2'b00);
    rd(8'h04, 32'h4);
    rd(8'h14, 32'h8A);
    chk("kdrive", 32'h1, kdrive);
    wr(8'h00, 32'h0);
    print_verdict();
  end
endmodule // usb_root_port_resume_connect_test
`default_nettype wire
